// >>> core/fbps_pkg.sv
package fbps_pkg;
  // ****************************************
  // clock and program timing
  // ****************************************
  localparam int CLK_MHZ    = 40;     // system clock rate
  localparam int T_STD_NS   = 40000;  // standard byte program time
  localparam int T_BURST_NS = 20000;  // burst byte program time
  // least times, so round up to whole cycles
  localparam int STD_CYC   = (T_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int BURST_CYC = (T_BURST_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W     = 12;      // timer counter width

  // ****************************************
  // apb register offsets
  // ****************************************
  localparam logic [7:0] REG_CONFIG = 8'h00;  // flash_config
  localparam logic [7:0] REG_FWRITE = 8'h04;  // array write: addr, data
  localparam logic [7:0] REG_CMD    = 8'h08;  // command launch
  localparam logic [7:0] REG_STATUS = 8'h0C;  // sequencer state

  // ****************************************
  // field layouts and reset values
  // ****************************************
  localparam int         CFG_KEY_EN  = 5;        // key-access enable
  localparam logic [7:0] CFG_RW_MASK = 8'hE0;    // bits 7..5 writable
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam int         FW_ADDR_LSB = 8;        // address in [23:8]
  localparam int         ST_PUMP     = 2;        // status bit positions
  localparam int         ST_BUSY     = 3;
  localparam int         ST_PEND     = 4;
  localparam int         ST_FAST     = 5;
  localparam int         ST_UNSEC    = 6;
  localparam int         ST_KEY_LSB  = 8;        // key bytes seen [15:8]
  localparam logic [15:0] KEY_LO     = 16'hFFB0; // backdoor_key_locations
  localparam logic [15:0] KEY_HI     = 16'hFFB7;
  localparam int         ROW_BITS    = 6;        // 64-byte rows
  localparam logic [1:0] SEC_UNSEC   = 2'b10;    // only unsecured code
  localparam logic [1:0] SEC_RESET   = 2'b11;    // secure until loaded

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_PROG  = 8'h01;
  localparam logic [7:0] CMD_BURST = 8'h02;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_BLANK = 8'h04;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_PROG = 3'b010,
    S_GAP  = 3'b100
  } fbps_state_t;
endpackage

// >>> core/fbps_seq.sv
`timescale 1ns/10ps
module fbps_seq
  import fbps_pkg::*;
#(
  parameter int ADDR_W = 8,   // apb address width
  parameter int KEY_N  = 8    // backdoor key bytes
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  // ****************************************
  // apb slave
  // ****************************************
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // ****************************************
  // flash array side
  // ****************************************
  input  wire logic [1:0]          sec_init,
  input  wire logic [KEY_N*8-1:0]  key_ref,
  input  wire logic                blank_ok,
  output logic                     pump_on,
  output logic      [15:0]         arr_addr,
  output logic      [7:0]          arr_data,
  output logic                     arr_prog,
  output logic                     arr_erase,
  output logic                     arr_blank,
  output logic                     burst_timing,
  output logic                     unsecured
);
  import fbps_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fbps_state_t         st;         // sequencer state
    logic [7:0]          cfg;        // flash_config
    logic [1:0]          sec;        // security_state_field
    logic                sec_loaded; // init copy taken
    logic                pump;       // charge pump enable
    logic                fast;       // current byte on burst time
    logic [7:0]          cmd;        // active command
    logic [15:0]         addr;       // active byte address
    logic [7:0]          data;       // active byte data
    logic                wr_valid;   // array write latched
    logic [15:0]         wr_addr;
    logic [7:0]          wr_data;
    logic                pend;       // queued burst command
    logic [15:0]         pend_addr;
    logic [7:0]          pend_data;
    logic [KEY_N*8-1:0]  key;        // comparison key bytes
    logic [KEY_N-1:0]    key_seen;   // bytes written so far
    logic                tstart;     // timer launch pulse
    logic                tlong;      // timer standard select
    logic                go_prog;    // array strobes, one cycle
    logic                go_erase;
    logic                go_blank;
    logic [31:0]         rdata;      // apb read data
  } fbps_core_t;

  localparam fbps_core_t CORE_RST = '{
    st:      S_IDLE,
    cfg:     CFG_RESET,
    sec:     SEC_RESET,
    default: '0
  };

  fbps_core_t r;       // registered state
  fbps_core_t next_r;  // next state

  fbps_tmr_if tmr ();  // link to step timer

  // ****************************************
  // helpers
  // ****************************************
  // true for any of the eight key locations; all 16 address
  // bits are compared, so no alias of the key area matches
  function automatic logic is_key_loc(input logic [15:0] a);
    is_key_loc = (a >= KEY_LO) && (a <= KEY_HI);
  endfunction

  // true for a mapped register offset
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_W'(REG_CONFIG)) ||
                (a == ADDR_W'(REG_FWRITE)) ||
                (a == ADDR_W'(REG_CMD))    ||
                (a == ADDR_W'(REG_STATUS));
  endfunction

  // start one timed step: pump on, strobe array, time it
  function automatic fbps_core_t launch(
    input fbps_core_t  c,
    input logic [7:0]  cmd,
    input logic [15:0] a,
    input logic [7:0]  d,
    input logic        fast
  );
    fbps_core_t o;
    o          = c;
    o.st       = S_PROG;
    o.cmd      = cmd;
    o.addr     = a;
    o.data     = d;
    o.pump     = 1'b1;
    o.fast     = fast;
    o.tstart   = 1'b1;
    o.tlong    = ~fast;
    o.go_prog  = (cmd == CMD_PROG) || (cmd == CMD_BURST);
    o.go_erase = (cmd == CMD_ERASE);
    o.go_blank = (cmd == CMD_BLANK);
    launch     = o;
  endfunction

  // ****************************************
  // next-state logic
  // ****************************************
  logic              wr_acc;     // apb write access phase
  logic              setup;      // apb setup phase
  logic [15:0]       fw_addr;    // address field of array write
  logic [7:0]        wcmd;       // command being written
  logic              seq_next;   // pending is next sequential byte
  logic              same_row;   // pending shares the active row
  logic              cmd_ok;     // written command is known

  always_comb begin
    next_r   = r;
    wr_acc   = psel && penable && pwrite;
    setup    = psel && !penable;
    fw_addr  = pwdata[FW_ADDR_LSB +: 16];
    wcmd     = pwdata[7:0];
    cmd_ok   = (wcmd == CMD_PROG) || (wcmd == CMD_BURST) ||
               (wcmd == CMD_ERASE) || (wcmd == CMD_BLANK);
    seq_next = (r.pend_addr == r.addr + 16'h0001);
    // a row ends where a5..a0 wrap to zero; the queued byte is
    // the next one, so a zero low field there means the active
    // byte closed its row
    same_row = (r.pend_addr[ROW_BITS-1:0] != '0);
    // strobes live for one cycle only
    next_r.tstart   = 1'b0;
    next_r.go_prog  = 1'b0;
    next_r.go_erase = 1'b0;
    next_r.go_blank = 1'b0;

    // security copy taken once, the cycle after reset
    if (!r.sec_loaded) begin
      next_r.sec        = sec_init;
      next_r.sec_loaded = 1'b1;
    end

    // ------------------------------------------------
    // sequencer
    // ------------------------------------------------
    case (r.st)
      S_IDLE: begin
        // a byte left over from a row change, a non-sequential burst byte or a late queue
        if (r.pend) begin
          next_r      = launch(next_r, CMD_BURST, r.pend_addr,
                               r.pend_data, 1'b0);
          next_r.pend = 1'b0;
        end
      end
      S_PROG: begin
        if (tmr.done) begin
          // completion: decide what the pump does now
          if ((r.cmd == CMD_BLANK) && blank_ok) begin
            next_r.sec = SEC_UNSEC;
          end
          if ((r.cmd == CMD_BURST) && r.pend) begin
            if (seq_next && same_row) begin
              // pump stays up, shorter burst time
              next_r      = launch(next_r, CMD_BURST, r.pend_addr,
                                   r.pend_data, 1'b1);
              next_r.pend = 1'b0;
            end else begin
              // high voltage drops, then rises again
              next_r.pump = 1'b0;
              next_r.fast = 1'b0;
              next_r.st   = S_GAP;
            end
          end else begin
            // nothing queued or plain command
            next_r.pump = 1'b0;
            next_r.fast = 1'b0;
            next_r.st   = S_IDLE;
          end
        end
      end
      S_GAP: begin
        // one cycle in S_GAP, then one in S_IDLE: the pump is off two cycles between rows; the
        // least drop that still lets high voltage fall and rise again
        next_r.st = S_IDLE;
      end
      default: begin
        next_r.st   = S_IDLE;
        next_r.pump = 1'b0;
      end
    endcase

    // ------------------------------------------------
    // apb writes take effect in the access phase
    // (pready is always high, so this is the one write edge)
    // ------------------------------------------------
    if (wr_acc) begin
      if (paddr == ADDR_W'(REG_CONFIG)) begin
        // low bits never store, so they read zero
        next_r.cfg = pwdata[7:0] & CFG_RW_MASK;
      end else if (paddr == ADDR_W'(REG_FWRITE)) begin
        if (is_key_loc(fw_addr) && r.cfg[CFG_KEY_EN]) begin
          // comparison key byte, no command starts
          next_r.key[fw_addr[2:0]*8 +: 8] = pwdata[7:0];
          next_r.key_seen[fw_addr[2:0]]   = 1'b1;
        end else begin
          // any other array write, key area included while key access is off, is the
          // first step of a program or erase command
          next_r.wr_addr  = fw_addr;
          next_r.wr_data  = pwdata[7:0];
          next_r.wr_valid = 1'b1;
        end
      end else if (paddr == ADDR_W'(REG_CMD)) begin
        if (cmd_ok && (r.wr_valid || wcmd == CMD_BLANK)) begin
          if ((r.st == S_IDLE) && !r.pend) begin
            next_r = launch(next_r, wcmd, r.wr_addr,
                            r.wr_data, 1'b0);
            next_r.wr_valid = 1'b0;
          end else if ((r.st == S_PROG) && (r.cmd == CMD_BURST) &&
                       (wcmd == CMD_BURST) && !r.pend) begin
            // one queued burst byte beside the active
            next_r.pend      = 1'b1;
            next_r.pend_addr = r.wr_addr;
            next_r.pend_data = r.wr_data;
            next_r.wr_valid  = 1'b0;
          end
          // anything else is dropped: the sequencer has no
          // room, and status shows it is busy or has a byte pending
        end
      end
    end

    // ------------------------------------------------
    // backdoor key compare once all bytes are in
    // ------------------------------------------------
    if (&r.key_seen) begin
      if (r.key == key_ref) begin
        next_r.sec = SEC_UNSEC;
      end
      next_r.key_seen = '0;
    end

    // ------------------------------------------------
    // read data captured in the setup phase
    // ------------------------------------------------
    if (setup) begin
      if (paddr == ADDR_W'(REG_CONFIG)) begin
        next_r.rdata = {24'h00_0000, r.cfg};
      end else if (paddr == ADDR_W'(REG_FWRITE)) begin
        next_r.rdata = {8'h00, r.wr_addr, r.wr_data};
      end else if (paddr == ADDR_W'(REG_CMD)) begin
        next_r.rdata = {24'h00_0000, r.cmd};
      end else if (paddr == ADDR_W'(REG_STATUS)) begin
        next_r.rdata = '0;
        next_r.rdata[1:0]      = r.sec;
        next_r.rdata[ST_PUMP]  = r.pump;
        // a running timer counts too, so a step in flight shows
        next_r.rdata[ST_BUSY]  = (r.st != S_IDLE) || tmr.busy;
        next_r.rdata[ST_PEND]  = r.pend;
        next_r.rdata[ST_FAST]  = r.fast;
        next_r.rdata[ST_UNSEC] = (r.sec == SEC_UNSEC);
        next_r.rdata[ST_KEY_LSB +: KEY_N] = r.key_seen;
      end else begin
        next_r.rdata = '0;
      end
    end
  end

  // ****************************************
  // state register, synchronous reset
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // step timer
  // ****************************************
  assign tmr.start    = r.tstart;
  assign tmr.long_sel = r.tlong;

  fbps_timer #(
    .CNT_W     (CNT_W),
    .STD_CYC   (STD_CYC),
    .BURST_CYC (BURST_CYC)
  ) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .t      (tmr)
  );

  // ****************************************
  // outputs
  // ****************************************
  // zero wait states; handshake is combinational
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !is_mapped(paddr);
  assign prdata       = r.rdata;
  assign pump_on      = r.pump;
  assign arr_addr     = r.addr;
  assign arr_data     = r.data;
  // strobes come from flip-flops, so the array sees clean pulses
  assign arr_prog     = r.go_prog;
  assign arr_erase    = r.go_erase;
  assign arr_blank    = r.go_blank;
  assign burst_timing = r.fast;
  // only one of the four codes opens the flash
  assign unsecured    = (r.sec == SEC_UNSEC);
endmodule

// >>> core/fbps_timer.sv
`timescale 1ns/10ps
// ****************************************
// program step timer
// ****************************************
module fbps_timer #(
  parameter int CNT_W     = fbps_pkg::CNT_W,
  parameter int STD_CYC   = fbps_pkg::STD_CYC,
  parameter int BURST_CYC = fbps_pkg::BURST_CYC
) (
  input  wire logic  clk,
  input  wire logic  resetn,
  fbps_tmr_if.tmr    t
);
  import fbps_pkg::*;

  // whole timer state
  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // cycles left
    logic             busy;  // counting
    logic             done;  // end pulse
  } fbps_tmr_t;

  fbps_tmr_t r;       // registered state
  fbps_tmr_t next_r;  // next state

  // ****************************************
  // count down, pulse done at zero
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (t.start) begin
      // a start restarts even a running count
      next_r.busy = 1'b1;
      next_r.cnt  = t.long_sel ? CNT_W'(STD_CYC - 1)
                               : CNT_W'(BURST_CYC - 1);
    end else if (r.busy) begin
      if (r.cnt == '0) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - 1'b1;
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign t.done = r.done;
  assign t.busy = r.busy;
endmodule

// >>> core/fbps_tmr_if.sv
`timescale 1ns/10ps
// ****************************************
// sequencer to program timer link
// ****************************************
interface fbps_tmr_if;
  logic start;     // one-cycle launch
  logic long_sel;  // 1: standard time, 0: burst time
  logic done;      // one-cycle end of timed step
  logic busy;      // timer running
  modport ctrl (output start, output long_sel, input done, input busy);
  modport tmr  (input start, input long_sel, output done, output busy);
endinterface

// >>> tb/fbps_flash_model.sv
`timescale 1ns/10ps
// ****************************************
// flash array stand-in
// ****************************************
module fbps_flash_model
  import fbps_pkg::*;
#(
  parameter logic [63:0] KEY = 64'h0123_4567_89AB_CDEF  // arbitrary key
) (
  input  wire logic        clk,
  output logic      [1:0]  sec_init,
  output logic      [63:0] key_ref,
  output logic             blank_ok,
  input  wire logic        arr_prog,
  input  wire logic        arr_erase
);
  // contents survive reset, so no reset here
  logic programmed = 1'b1;  // array holds data at power-up
  assign sec_init = SEC_RESET;  // stored field reads secure
  assign key_ref  = KEY;
  assign blank_ok = !programmed;  // blank only after an erase
  // track whether any byte was written since the last erase
  always @(posedge clk) begin
    if (arr_erase) begin
      programmed <= 1'b0;
    end else if (arr_prog) begin
      programmed <= 1'b1;
    end
  end
endmodule

// >>> tb/fbps_seq_properties.sv
`timescale 1ns/10ps
// ****************************************
// port checker for the sequencer
// ****************************************
module fbps_seq_checker
  import fbps_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int KEY_N  = 8
) (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [ADDR_W-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [1:0]         sec_init,
  input wire logic [KEY_N*8-1:0] key_ref,
  input wire logic               blank_ok,
  input wire logic               pump_on,
  input wire logic [15:0]        arr_addr,
  input wire logic [7:0]         arr_data,
  input wire logic               arr_prog,
  input wire logic               arr_erase,
  input wire logic               arr_blank,
  input wire logic               burst_timing,
  input wire logic               unsecured
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0]  cfg_shadow;  // expected config contents
  logic        blank_seen;  // a blank check was launched
  logic [15:0] last_addr;   // address of previous programmed byte
  int          quiet_cnt;   // pump-on cycles since last launch
  logic        unmapped;
  assign unmapped = !(paddr inside {REG_CONFIG, REG_FWRITE, REG_CMD,
                                    REG_STATUS});
  // helper state: mirrors what software wrote and what was launched
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_shadow <= 8'h00;
      blank_seen <= 1'b0;
      last_addr  <= 16'h0000;
      quiet_cnt  <= 0;
    end else begin
      if (psel && penable && pwrite && paddr == REG_CONFIG) begin
        cfg_shadow <= pwdata[7:0] & CFG_RW_MASK;
      end
      if (arr_blank) begin
        blank_seen <= 1'b1;
      end
      if (arr_prog) begin
        last_addr <= arr_addr;
      end
      // a blank check is a timed step as well
      if (!pump_on || arr_prog || arr_erase || arr_blank) begin
        quiet_cnt <= 0;
      end else begin
        quiet_cnt <= quiet_cnt + 1;
      end
    end
  end
  sequence acc_s;
    psel && penable;
  endsequence
  sequence cfg_rd_s;
    psel && penable && !pwrite && paddr == REG_CONFIG;
  endsequence
  sequence burst_step_s;
    arr_prog && burst_timing;
  endsequence
  cfg_read_a: assert property (
    cfg_rd_s |-> prdata == {24'h0, cfg_shadow})
    else $error("config read mismatch");
  addr_map_a: assert property (acc_s |-> pslverr == unmapped)
    else $error("slave error wrong");
  pump_launch_a: assert property ((arr_prog || arr_erase) |-> pump_on)
    else $error("pump off at launch");
  pump_release_a: assert property (quiet_cnt <= STD_CYC + 8)
    else $error("pump left on");
  std_first_a: assert property ($rose(pump_on) |-> !burst_timing)
    else $error("fresh pump on burst time");
  row_start_a: assert property (
    arr_prog && arr_addr[5:0] == 6'h00 |-> !burst_timing)
    else $error("row start on burst time");
  burst_keep_a: assert property (
    $rose(burst_timing) |-> $past(pump_on) && pump_on)
    else $error("burst time without kept pump");
  burst_seq_a: assert property (
    burst_step_s |-> arr_addr == last_addr + 16'h0001)
    else $error("burst byte not sequential");
  strobe_pulse_a: assert property (arr_prog |=> !arr_prog)
    else $error("program strobe too long");
  unsec_hold_a: assert property (unsecured |=> unsecured)
    else $error("unsecured state lost");
  unsec_cause_a: assert property (
    $rose(unsecured) && $past(resetn, 2)
    |-> cfg_shadow[CFG_KEY_EN] || blank_seen)
    else $error("unsecured without cause");
endmodule
bind fbps_seq fbps_seq_checker #(.ADDR_W(ADDR_W), .KEY_N(KEY_N)) u_chk (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sec_init(sec_init),
  .key_ref(key_ref), .blank_ok(blank_ok), .pump_on(pump_on),
  .arr_addr(arr_addr), .arr_data(arr_data), .arr_prog(arr_prog),
  .arr_erase(arr_erase), .arr_blank(arr_blank),
  .burst_timing(burst_timing), .unsecured(unsecured)
);

// >>> tb/fbps_tb_top.sv
`timescale 1ns/10ps
// ****************************************
// sequencer testbench
// ****************************************
module flash_burst_program_security_tb_top;
  import fbps_pkg::*;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;  // arbitrary
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, arr_data;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  sec_init;
  logic [63:0] key_ref;
  logic [15:0] arr_addr;
  logic        blank_ok, pump_on, arr_prog, arr_erase, arr_blank;
  logic        burst_timing, unsecured, err, watch;
  int          bad_count, total_checks, drops;
  fbps_seq #(.ADDR_W(8), .KEY_N(8)) DUT (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sec_init(sec_init),
    .key_ref(key_ref), .blank_ok(blank_ok), .pump_on(pump_on),
    .arr_addr(arr_addr), .arr_data(arr_data), .arr_prog(arr_prog),
    .arr_erase(arr_erase), .arr_blank(arr_blank),
    .burst_timing(burst_timing), .unsecured(unsecured));
  fbps_flash_model #(.KEY(KEY)) u_flash (
    .clk(clk), .sec_init(sec_init), .key_ref(key_ref),
    .blank_ok(blank_ok), .arr_prog(arr_prog), .arr_erase(arr_erase));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // count cycles with the pump off while a burst chain is watched
  always @(posedge clk) if (watch && pump_on !== 1'b1) drops <= drops + 1;
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // apb transfer; waits on pready, never assumes a latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // reset changes on a rising edge like every other input
  task do_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
  endtask
  // bounded waits, sampled just after the edge settles
  task wait_pump(input logic v);
    int n;
    for (n = 0; n < 3000 && pump_on !== v; n++) begin
      @(posedge clk); #1;
    end
    chk(pump_on === v, "pump wait expired");
  endtask
  // the strobe stands one cycle, so look just after each edge
  task wait_prog(input logic [15:0] a);
    int n;
    #1;
    for (n = 0; n < 3000; n++) begin
      if (arr_prog === 1'b1 && arr_addr === a) break;
      @(posedge clk);
      #1;
    end
    chk(arr_prog === 1'b1 && arr_addr === a, "program launch missing");
  endtask
  task launch(input logic [15:0] a, input logic [7:0] cmd);
    apb(1'b1, REG_FWRITE, {8'h00, a, 8'hA5});
    apb(1'b1, REG_CMD, {24'h0, cmd});
  endtask
  task t_config;
    apb(1'b1, REG_CONFIG, 32'h0000_00FF);
    apb(1'b0, REG_CONFIG, 32'h0000_0000);
    chk(rd === 32'h0000_00E0, "config bits");
    apb(1'b1, 8'h10, 32'h0000_0000);
    chk(err === 1'b1, "unmapped write accepted");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    $display("test config done");
  endtask
  task t_key;
    chk(unsecured === 1'b0, "secure after reset");
    apb(1'b1, REG_CONFIG, 32'h0000_0020);
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, REG_FWRITE, {8'h00, 16'(KEY_LO + n), KEY[8*n+:8]});
    end
    repeat (3) @(posedge clk);
    #1;
    chk(unsecured === 1'b1, "key match ignored");
    chk(pump_on === 1'b0, "key write started pump");
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd[1:0] === SEC_UNSEC && rd[ST_UNSEC] === 1'b1, "status");
    $display("test key done");
  endtask
  task t_prog;
    launch(16'hFFB2, CMD_PROG);
    wait_pump(1'b1);
    chk(arr_addr === 16'hFFB2 && burst_timing === 1'b0, "prog byte");
    chk(arr_data === 8'hA5, "prog data");
    wait_pump(1'b0);
    $display("test program done");
  endtask
  task t_blank;
    apb(1'b1, REG_CMD, {24'h0, CMD_BLANK});
    repeat (1700) @(posedge clk);
    #1;
    chk(unsecured === 1'b0, "unsecured with data");
    launch(16'h1000, CMD_ERASE);
    wait_pump(1'b1);
    wait_pump(1'b0);
    apb(1'b1, REG_CMD, {24'h0, CMD_BLANK});
    for (int n = 0; n < 2000 && unsecured !== 1'b1; n++) @(posedge clk);
    chk(unsecured === 1'b1, "blank check ignored");
    $display("test blank done");
  endtask
  task t_burst;
    launch(16'h203E, CMD_BURST);
    wait_prog(16'h203E);
    chk(pump_on === 1'b1 && burst_timing === 1'b0, "first burst");
    drops = 0;
    watch = 1'b1;
    launch(16'h203F, CMD_BURST);
    wait_prog(16'h203F);
    watch = 1'b0;
    chk(drops === 0, "pump dropped in row");
    @(posedge clk); #1;
    chk(burst_timing === 1'b1, "burst time missing");
    drops = 0;
    watch = 1'b1;
    launch(16'h2040, CMD_BURST);
    wait_prog(16'h2040);
    watch = 1'b0;
    chk(drops > 0, "pump kept across row");
    chk(burst_timing === 1'b0, "row start on burst time");
    wait_pump(1'b0);
    $display("test burst done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    results();
  end
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; watch = 1'b0; drops = 0;
    do_reset();
    t_config();
    t_key();
    do_reset();
    t_prog();
    t_blank();
    t_burst();
    results();
  end
endmodule
